// ---- tb/reset_pin_scan_model.sv ----
// far side: drives the external reset pin and the scan reset register bit
// assumes requests start just after a rising edge of core_clk_in
`timescale 1ns/100ps
module reset_pin_scan_model (
   // clock
   input  wire logic core_clk_in,
   // pin and scan bit
   output logic      rst_pin_n_out,
   output logic      scan_reset_out
);
   // pin has a pull-up, so it idles high
   initial begin
      rst_pin_n_out  = 1'b1;
      scan_reset_out = 1'b0;
   end

   task automatic pin_low(input int n);
      rst_pin_n_out <= 1'b0;
      repeat (n) @(posedge core_clk_in);
      rst_pin_n_out <= 1'b1;
   endtask

   task automatic scan_hold(input int n);
      scan_reset_out <= 1'b1;
      repeat (n) @(posedge core_clk_in);
      scan_reset_out <= 1'b0;
   endtask
endmodule

// ---- tb/reset_source_sequencer_test.sv ----
// testbench of the reset sequencer with short delay and filter counts
// assumes the far-side model drives the pin and scan bit
`timescale 1ns/100ps
module reset_source_sequencer_test;
   localparam int unsigned BASE = 4;
   localparam int unsigned BMIN = 4;
   logic                    clk, rst, por, wdt, bod, sfuse, pin_n, scan;
   logic [2:0]              lvl;
   logic [1:0]              csel;
   reset_seq_pkg::apb_req_s req;
   reset_seq_pkg::apb_rsp_s rsp;
   logic                    irst, start, bod_en, scan_en, err;
   logic [31:0]             rd;
   int                      miscompares, total_checks, cyc;

   reset_source_sequencer #(.DELAY_BASE_CYC(BASE), .BOD_MIN_CYC(BMIN))
   i_reset_source_sequencer (
      .core_clk_in(clk), .rst_in(rst), .por_in(por),
      .rst_pin_n_in(pin_n), .wdt_timeout_in(wdt), .bod_low_in(bod),
      .scan_reset_in(scan), .brownout_level_fuses_in(lvl),
      .clock_select_fuses_in(csel), .scan_fuse_in(sfuse),
      .apb_req_in(req), .apb_rsp_out(rsp), .int_rst_out(irst),
      .core_start_out(start), .bod_enable_out(bod_en),
      .scan_if_enable_out(scan_en));

   reset_pin_scan_model i_reset_pin_scan_model (
      .core_clk_in(clk), .rst_pin_n_out(pin_n), .scan_reset_out(scan));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // waits for pready with no cycle limit; only the run limit ends a hang
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      // one idle edge, so the next call never drives req in this step
      @(posedge clk);
   endtask

   // waits for release; stretch must span the load, then one start pulse
   task automatic wait_rel(input int load);
      int n;
      n = 0;
      while (irst === 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      check(n >= load && n <= load + 4, 1);
      check(start, 1);
      @(posedge clk);
      check(start, 0);
   endtask

   task automatic t_regs;
      apb(0, 8'h00, 0); check(rd, 32'h01);
      apb(1, 8'h00, 32'he0); apb(0, 8'h00, 0); check(rd, 32'he0);
      check(scan_en, 0);
      apb(1, 8'h00, 0); repeat (2) @(posedge clk);
      check(scan_en, 1);
      apb(0, 8'h08, 0); check(err, 1);
   endtask

   task automatic t_wdt;
      wdt <= 1'b1; @(posedge clk); wdt <= 1'b0;
      repeat (2) @(posedge clk);
      check(irst, 1);
      wait_rel(BASE);
      apb(0, 8'h00, 0); check(rd, 32'h08);
      apb(1, 8'h00, 0);
   endtask

   task automatic t_pin;
      csel <= 2'h2;
      fork
         i_reset_pin_scan_model.pin_low(3);
         begin #1; check(irst, 1); end
      join
      wait_rel(BASE << 2);
      apb(0, 8'h00, 0); check(rd, 32'h02);
      apb(1, 8'h00, 0);
      csel <= 2'h0;
   endtask

   task automatic t_scan;
      i_reset_pin_scan_model.scan_hold(12);
      check(irst, 1);
      wait_rel(BASE);
      apb(0, 8'h00, 0); check(rd, 32'h10);
      apb(1, 8'h00, 0);
   endtask

   task automatic brownout_min_pulse;
      for (int i = 0; i < 8; i++) begin
         lvl <= 3'(i); repeat (3) @(posedge clk);
         check(bod_en, i >= 3 && i <= 6);
      end
      bod <= 1'b1; repeat (10) @(posedge clk);
      check(irst, 0);
      bod <= 1'b0; lvl <= 3'h6; repeat (3) @(posedge clk);
      bod <= 1'b1; @(posedge clk);
      bod <= 1'b0; repeat (3) @(posedge clk);
      check(irst, 0);
      bod <= 1'b1; repeat (BMIN) @(posedge clk);
      bod <= 1'b0; repeat (3) @(posedge clk);
      check(irst, 0);
      bod <= 1'b1; repeat (BMIN + 4) @(posedge clk);
      check(irst, 1);
      bod <= 1'b0;
      wait_rel(BASE);
      apb(0, 8'h00, 0); check(rd, 32'h04);
      apb(0, 8'h04, 0); check(rd, 32'h0040_0000);
   endtask

   task automatic t_por;
      apb(1, 8'h00, 32'h24);
      por <= 1'b1; repeat (4) @(posedge clk); por <= 1'b0;
      wait_rel(BASE);
      apb(0, 8'h00, 0); check(rd, 32'h21);
   endtask

   task automatic final_report;
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // run limit well above the couple of hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         final_report;
      end
   end

   initial begin
      {rst, por, wdt, bod} = 4'b1000;
      sfuse = 1'b1;
      lvl = 3'h7;
      csel = 2'h0;
      req = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_wdt;
      t_pin;
      t_scan;
      brownout_min_pulse;
      t_por;
      final_report;
   end
endmodule

// ---- verilog/bod_pulse_filter.sv ----
// brown-out pulse-width filter: passes the under-voltage level only once
// it has stood longer than MIN_CYC consecutive clocks; assumes a
// synchronous input
`timescale 1ns/100ps
module bod_pulse_filter #(
   parameter int unsigned MIN_CYC = reset_seq_pkg::BOD_MIN_CYC
) (
   // clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   // level in and out
   input  wire logic enable_in,
   input  wire logic low_in,
   output logic      hit_out
);
   localparam int unsigned W = reset_seq_pkg::CNT_W;
   // a dip of exactly MIN_CYC clocks is not longer than the minimum
   localparam logic [W-1:0] LAST = W'(MIN_CYC);

   reset_seq_pkg::filt_state_s st_r;
   reset_seq_pkg::filt_state_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!(enable_in && low_in)) begin
         st_nxt.cnt = '0;
         st_nxt.hit = 1'b0;
      end else if (st_r.cnt >= LAST) begin
         st_nxt.hit = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hit_out = st_r.hit;

endmodule

// ---- verilog/reset_seq_pkg.sv ----
// constants, field layout and carrier types of the reset sequencer;
// assumes a 125 MHz system clock and an APB master with 32-bit data
package reset_seq_pkg;

   // timing
   localparam int unsigned CLK_MHZ     = 125;
   localparam int unsigned BOD_MIN_US  = 2;
   localparam int unsigned BOD_MIN_CYC = (BOD_MIN_US * CLK_MHZ);
   localparam int unsigned CNT_W       = 16;

   // register byte addresses
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] INFO_OFS   = 8'h04;

   // status fields
   localparam int unsigned POR_BIT  = 0;
   localparam int unsigned PIN_BIT  = 1;
   localparam int unsigned BOD_BIT  = 2;
   localparam int unsigned WD_BIT   = 3;
   localparam int unsigned SCAN_BIT = 4;
   localparam int unsigned DIS_BIT  = 7;
   localparam int unsigned NUM_SRC  = 5;
   localparam logic [7:0]  STATUS_RST = 8'h01;

   // brown-out level fuse coding
   localparam logic [2:0] BOD_OFF       = 3'h7;
   localparam logic [2:0] BOD_LOWEST_OK = 3'h3;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef struct packed {
      logic [CNT_W-1:0]   cnt;
      logic               core_rst;
      logic               start;
      logic               wd_pulse;
      logic               wd_prev;
      logic [NUM_SRC-1:0] src_prev;
      logic [7:0]         status;
      logic               bod_en;
      logic               scan_en;
      apb_rsp_s           rsp;
   } seq_state_s;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             hit;
   } filt_state_s;

endpackage

// ---- verilog/reset_source_sequencer.sv ----
// reset sequencer: combines five reset sources, stretches internal reset
// by a fuse-selected delay and records the cause in a status register;
// assumes detector outputs synchronous to core_clk_in and an APB master
`timescale 1ns/100ps
module reset_source_sequencer #(
   parameter int unsigned DELAY_BASE_CYC = 1024,
   parameter int unsigned BOD_MIN_CYC    = reset_seq_pkg::BOD_MIN_CYC
) (
   // clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  rst_in,
   // reset sources
   input  wire logic                  por_in,
   input  wire logic                  rst_pin_n_in,
   input  wire logic                  wdt_timeout_in,
   input  wire logic                  bod_low_in,
   input  wire logic                  scan_reset_in,
   // configuration fuses
   input  wire logic [2:0]            brownout_level_fuses_in,
   input  wire logic [1:0]            clock_select_fuses_in,
   input  wire logic                  scan_fuse_in,
   // register bus
   input  wire reset_seq_pkg::apb_req_s apb_req_in,
   output reset_seq_pkg::apb_rsp_s    apb_rsp_out,
   // reset and control outputs
   output logic                       int_rst_out,
   output logic                       core_start_out,
   output logic                       bod_enable_out,
   output logic                       scan_if_enable_out
);
   localparam int unsigned W = reset_seq_pkg::CNT_W;
   localparam int unsigned N = reset_seq_pkg::NUM_SRC;

   reset_seq_pkg::seq_state_s st_r;
   reset_seq_pkg::seq_state_s st_nxt;

   logic          int_rst_r;
   logic          bod_hit;
   logic          bod_en_now;
   logic          hard_src;
   logic [N-1:0]  src;
   logic [N-1:0]  rise;
   logic          any_src;
   logic [W-1:0]  delay_load;
   logic          setup;
   logic          access;
   logic          mapped;

   assign bod_en_now = (brownout_level_fuses_in != reset_seq_pkg::BOD_OFF)
                    && (brownout_level_fuses_in >=
                        reset_seq_pkg::BOD_LOWEST_OK);

   bod_pulse_filter #(
      .MIN_CYC (BOD_MIN_CYC)
   ) u_bod_filter (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .enable_in   (bod_en_now),
      .low_in      (bod_low_in),
      .hit_out     (bod_hit)
   );

   assign src = {scan_reset_in, st_r.wd_pulse, bod_hit,
                 ~rst_pin_n_in, por_in};
   assign rise = src & ~st_r.src_prev;
   assign any_src = |src;

   assign delay_load = W'(DELAY_BASE_CYC) << clock_select_fuses_in;

   assign setup  = apb_req_in.psel && !apb_req_in.penable;
   assign access = apb_req_in.psel && apb_req_in.penable
                && st_r.rsp.pready;
   assign mapped = (apb_req_in.paddr == reset_seq_pkg::STATUS_OFS)
                || (apb_req_in.paddr == reset_seq_pkg::INFO_OFS);

   always_comb begin
      st_nxt = st_r;

      st_nxt.wd_prev  = wdt_timeout_in;
      st_nxt.wd_pulse = wdt_timeout_in && !st_r.wd_prev;
      st_nxt.src_prev = src;

      // delay reloads while any source stands
      if (any_src) begin
         st_nxt.cnt = delay_load;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end

      st_nxt.core_rst = any_src || (st_r.cnt != '0);
      st_nxt.start = st_r.core_rst && !st_nxt.core_rst;

      // zero write clears a flag; ones leave it
      if (access && apb_req_in.pwrite
          && apb_req_in.paddr == reset_seq_pkg::STATUS_OFS) begin
         st_nxt.status[4:0] = st_r.status[4:0] & apb_req_in.pwdata[4:0];
         st_nxt.status[7:5] = apb_req_in.pwdata[7:5];
      end
      if (por_in) begin
         st_nxt.status[4:1] = 4'h0;
      end
      st_nxt.status[4:0] = st_nxt.status[4:0] | rise;
      if (por_in) begin
         st_nxt.status[reset_seq_pkg::POR_BIT] = 1'b1;
      end

      st_nxt.bod_en = bod_en_now;
      st_nxt.scan_en = scan_fuse_in
                    && !st_r.status[reset_seq_pkg::DIS_BIT];

      // apb: ready in the first access cycle
      st_nxt.rsp.pready  = setup;
      st_nxt.rsp.pslverr = setup && !mapped;
      st_nxt.rsp.prdata  = '0;
      if (setup && !apb_req_in.pwrite) begin
         if (apb_req_in.paddr == reset_seq_pkg::STATUS_OFS) begin
            st_nxt.rsp.prdata = {24'h0, st_r.status};
         end else if (apb_req_in.paddr == reset_seq_pkg::INFO_OFS) begin
            st_nxt.rsp.prdata = {8'h0, st_r.core_rst, st_r.bod_en,
                                 1'b0, src, st_r.cnt};
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r          <= '0;
         st_r.core_rst <= 1'b1;
         st_r.status   <= reset_seq_pkg::STATUS_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hard_src = rst_in | por_in | ~rst_pin_n_in | scan_reset_in;

   always_ff @(posedge core_clk_in or posedge hard_src) begin
      if (hard_src) begin
         int_rst_r <= 1'b1;
      end else begin
         int_rst_r <= st_nxt.core_rst;
      end
   end

   assign int_rst_out        = int_rst_r;
   assign core_start_out     = st_r.start;
   assign bod_enable_out     = st_r.bod_en;
   assign scan_if_enable_out = st_r.scan_en;
   assign apb_rsp_out        = st_r.rsp;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   a_wd_one_cycle: assert property (
      $rose(wdt_timeout_in) |=> st_r.wd_pulse ##1 !st_r.wd_pulse)
      else $error("watchdog pulse not one cycle");

   a_delay_reload: assert property (
      any_src |=> st_r.cnt == $past(delay_load))
      else $error("delay counter not loaded from fuses");

   a_release_after: assert property (
      $fell(int_rst_out) |-> $past(st_r.cnt) == '0 && !$past(any_src))
      else $error("reset released before delay ran out");

   a_src_holds_rst: assert property (
      any_src |=> int_rst_out)
      else $error("source active but reset low");

   a_scan_holds: assert property (
      scan_reset_in |-> int_rst_out)
      else $error("scan reset not holding reset");

   a_pin_async: assert property (
      !rst_pin_n_in |-> int_rst_out)
      else $error("pin low without reset");

   a_por_flag: assert property (
      por_in |=> st_r.status[reset_seq_pkg::POR_BIT])
      else $error("power-on flag not set");

   a_wd_flag: assert property (
      st_r.wd_pulse && !$past(st_r.wd_pulse)
      |=> st_r.status[reset_seq_pkg::WD_BIT])
      else $error("watchdog flag not set");

   a_pin_flag: assert property (
      $fell(rst_pin_n_in) |=> st_r.status[reset_seq_pkg::PIN_BIT])
      else $error("pin flag not set");

   a_scan_flag: assert property (
      $rose(scan_reset_in) |=> st_r.status[reset_seq_pkg::SCAN_BIT])
      else $error("scan flag not set");

   a_bod_short_dip: assert property (
      $rose(bod_low_in) ##1 !bod_low_in |=> !bod_hit)
      else $error("short brown-out dip acted on");

   a_bod_fuse_off: assert property (
      brownout_level_fuses_in == reset_seq_pkg::BOD_OFF
      |=> !bod_enable_out)
      else $error("brown-out enabled with off code");

   a_scan_disable: assert property (
      st_r.status[reset_seq_pkg::DIS_BIT] |=> !scan_if_enable_out)
      else $error("scan interface not disabled");

   a_start_release: assert property (
      core_start_out |-> !int_rst_out && $past(int_rst_out))
      else $error("start pulse without reset release");

   c_wd_reset: cover property (st_r.wd_pulse ##[1:20] !int_rst_out);
   c_bod_hit: cover property ($rose(bod_hit));
   c_release: cover property (core_start_out);
   c_flag_write: cover property (access && apb_req_in.pwrite);

endmodule
